// *** shared/arf_cfg.svh ***
// Purpose: offsets, field positions, reset values and code limits for the result formatter
// Assumes: 10-bit converter core on the same clock
// Notes:   definitions only
`ifndef ARF_CFG_SVH
`define ARF_CFG_SVH

`define ARF_RES_BITS      10
`define ARF_CODE_ZERO     10'h000
`define ARF_CODE_FULL     10'h3FF
`define ARF_BIP_MAX       10'h1FF
`define ARF_BIP_MIN       10'h200
`define ARF_GAIN_LOW      5'h08
`define ARF_GAIN_HIGH     5'h14
`define ARF_MUX_DIFF_POS  4
`define ARF_MUX_GAIN_POS  0
`define ARF_MUX_TEMP      5'h0B
`define ARF_MUX_RESET     5'h00
`define ARF_REFS_1V1      2'h1
`define ARF_REFS_2V56     2'h3
`define ARF_SIGN_POS      9
`define ARF_BYTE_RESET    8'h00
`define ARF_PAD_HIGH      6'h00
`define ARF_PAD_LOW       6'h00

`endif

// *** shared/arf_pkg.sv ***
// Purpose: types shared by the result formatter files
// Assumes: constants come from arf_cfg.svh
// Notes:   state codes are one-hot
`include "arf_cfg.svh"
package arf_pkg;

    typedef enum logic [1:0] {
        ARF_IDLE = 2'b01,
        ARF_CONV = 2'b10
    } arf_state_t;

    typedef enum logic [1:0] {
        ARF_REF_AVCC    = 2'h0,
        ARF_REF_EXT     = 2'h1,
        ARF_REF_INT_1V1 = 2'h2,
        ARF_REF_INT_2V5 = 2'h3
    } arf_ref_t;

    typedef struct packed {
        arf_state_t fsm;
        logic [9:0] result;
        logic       flag;
        logic [7:0] low;
        logic [7:0] high;
        logic [4:0] mux_lock;
        logic       bip_lock;
        arf_ref_t   ref_src;
        logic       ref_drive;
        logic       ref_high;
        logic       temp_err;
    } arf_regs_t;

endpackage : arf_pkg

// *** rtl/arf_code_calc.sv ***
// Purpose: turns the sampled input levels into a 10-bit result code
// Assumes: samples are already scaled as level * 1024 / reference
// Notes:   purely combinational; the caller registers the code
`timescale 1ns/1ps
`include "arf_cfg.svh"
module arf_code_calc
    import arf_pkg::*;
(
    input  wire logic [9:0] pos_sample,   // positive input level code
    input  wire logic [9:0] neg_sample,   // negative input level code
    input  wire logic       diff_en,      // differential pair selected
    input  wire logic       gain_high,    // 20x gain instead of 8x
    input  wire logic       bipolar,      // two's complement mode
    output logic      [9:0] code          // formatted result code
);

    // clamp a signed product into a signed window, used by both modes
    function automatic logic [9:0] arf_clamp(input logic signed [16:0] value,
                                             input logic signed [16:0] lo,
                                             input logic signed [16:0] hi);
        logic signed [16:0] v;
        v = value;
        if (v < lo) begin
            v = lo;
        end
        if (v > hi) begin
            v = hi;
        end
        return v[9:0];
    endfunction : arf_clamp

    logic        [4:0]  gain;
    logic signed [10:0] diff;
    logic signed [16:0] prod;

    // gain and signed difference feed both differential forms
    always_comb begin
        gain = gain_high ? `ARF_GAIN_HIGH : `ARF_GAIN_LOW;
        diff = $signed({1'b0, pos_sample}) - $signed({1'b0, neg_sample});
        // widen before multiplying: a 20x product needs 16 bits, not the operands' 11
        prod = 17'(diff) * 17'($signed({1'b0, gain}));
    end

    // code selection by conversion type
    always_comb begin
        if (!diff_en) begin
            code = pos_sample;
        end else if (bipolar) begin
            code = arf_clamp(prod >>> 1, -17'sd512, 17'sd511);
        end else begin
            code = arf_clamp(prod, 17'sd0, 17'sd1023);
        end
    end

endmodule : arf_code_calc

// *** rtl/arf_result_refout.sv ***
// Purpose: result formatting and reference output control of the converter
// Assumes: sample strobe and control bits come from logic on the same clock
// Notes:   one conversion is in flight at a time
`timescale 1ns/1ps
`include "arf_cfg.svh"
module arf_result_refout
    import arf_pkg::*;
#(
    parameter int RES_BITS = `ARF_RES_BITS
)(
    input  wire logic       clock,                        // 100 MHz clock
    input  wire logic       rst,                          // synchronous reset, high
    input  wire logic       converter_enable,             // converter switched on
    input  wire logic       conversion_start,             // start pulse
    input  wire logic       sample_valid,                 // core finished sampling, pulse
    input  wire logic [9:0] pos_sample,                   // positive input code
    input  wire logic [9:0] neg_sample,                   // negative input code
    input  wire logic [4:0] input_channel_select,         // channel and gain select
    input  wire logic       bipolar_select,               // bipolar differential mode
    input  wire logic       left_adjust_select,           // left adjust presentation
    input  wire logic [1:0] reference_select,             // reference select field
    input  wire logic       external_reference_enable,    // external reference pin used
    input  wire logic       reference_output_enable,      // reference output enable
    input  wire logic       flag_clear,                   // clear done flag, pulse
    output logic            conversion_busy,              // conversion in progress
    output logic            conversion_done_flag,         // result ready, sticky
    output logic      [7:0] result_low_byte,              // low result register
    output logic      [7:0] result_high_byte,             // high result register
    output logic            result_sign_bit,              // top result bit
    output arf_ref_t        reference_source,             // reference used by core
    output logic            reference_output_drive,       // drive enable of reference pin
    output logic            reference_output_level_high,  // 2.56V instead of 1.1V
    output logic            temp_setup_error              // temperature without 1.1V
);

    // only the 10-bit datapath exists
    if (RES_BITS != 10) begin : g_bad_width
        $error("arf_result_refout supports RES_BITS of 10 only");
    end

    localparam arf_regs_t ARF_REGS_RESET = '{
        fsm:       ARF_IDLE,
        result:    `ARF_CODE_ZERO,
        flag:      1'b0,
        low:       `ARF_BYTE_RESET,
        high:      `ARF_BYTE_RESET,
        mux_lock:  `ARF_MUX_RESET,
        bip_lock:  1'b0,
        ref_src:   ARF_REF_AVCC,
        ref_drive: 1'b0,
        ref_high:  1'b0,
        temp_err:  1'b0
    };

    // reference decode, also used by the temperature setup check
    // select and external enable
    function automatic arf_ref_t arf_ref_decode(input logic [1:0] refs,
                                                input logic       ext_en);
        arf_ref_t r;
        r = ARF_REF_AVCC;
        if (!refs[0]) begin
            r = ext_en ? ARF_REF_EXT : ARF_REF_AVCC;
        end else if (!ext_en) begin
            r = refs[1] ? ARF_REF_INT_2V5 : ARF_REF_INT_1V1;
        end
        return r;
    endfunction : arf_ref_decode

    // byte split of the stored result as high and low registers
    // left or right adjusted split
    function automatic logic [15:0] arf_present(input logic [9:0] res,
                                                input logic       left);
        logic [15:0] p;
        if (left) begin
            p = {res, `ARF_PAD_LOW};
        end else begin
            p = {`ARF_PAD_HIGH, res};
        end
        return p;
    endfunction : arf_present

    arf_regs_t  st;
    arf_regs_t  next_st;
    logic [9:0] calc_code;
    logic       finish;

    // code arithmetic runs on the channel locked at start
    arf_code_calc u_calc (
        .pos_sample (pos_sample),
        .neg_sample (neg_sample),
        .diff_en    (st.mux_lock[`ARF_MUX_DIFF_POS]),
        .gain_high  (st.mux_lock[`ARF_MUX_GAIN_POS]),
        .bipolar    (st.bip_lock),
        .code       (calc_code)
    );

    assign finish = (st.fsm == ARF_CONV) && converter_enable && sample_valid;

    // next state of the whole block
    always_comb begin
        next_st = st;
        unique case (st.fsm)
            ARF_IDLE: begin
                // selection tracks software until a conversion locks it
                next_st.ref_src = arf_ref_decode(reference_select, external_reference_enable);
                if (converter_enable && conversion_start) begin
                    next_st.fsm      = ARF_CONV;
                    next_st.mux_lock = input_channel_select;
                    next_st.bip_lock = bipolar_select;
                end
            end
            ARF_CONV: begin
                if (!converter_enable) begin
                    next_st.fsm = ARF_IDLE;   // switching off aborts, old result kept
                end else if (sample_valid) begin
                    next_st.fsm    = ARF_IDLE;
                    next_st.result = calc_code;
                end
            end
            default: begin
                next_st.fsm = ARF_IDLE;
            end
        endcase
        if (finish) begin
            next_st.flag = 1'b1;
        end else if (flag_clear) begin
            next_st.flag = 1'b0;
        end
        {next_st.high, next_st.low} = arf_present(next_st.result, left_adjust_select);
        next_st.ref_drive = converter_enable && reference_output_enable
                            && reference_select[0];
        next_st.ref_high  = reference_select[1];
        next_st.temp_err  = (input_channel_select == `ARF_MUX_TEMP)
                            && (arf_ref_decode(reference_select, external_reference_enable)
                                != ARF_REF_INT_1V1);
    end

    // single register stage for all state
    always_ff @(posedge clock) begin
        if (rst) begin
            st <= ARF_REGS_RESET;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign conversion_busy             = (st.fsm == ARF_CONV);
    assign conversion_done_flag        = st.flag;
    assign result_low_byte             = st.low;
    assign result_high_byte            = st.high;
    assign result_sign_bit             = st.result[`ARF_SIGN_POS];
    assign reference_source            = st.ref_src;
    assign reference_output_drive      = st.ref_drive;
    assign reference_output_level_high = st.ref_high;
    assign temp_setup_error            = st.temp_err;

    // expected unipolar product, read only by the checks below
    logic [14:0] uni_expect;
    assign uni_expect = 15'(pos_sample - neg_sample)
                        * 15'(st.mux_lock[`ARF_MUX_GAIN_POS] ? `ARF_GAIN_HIGH : `ARF_GAIN_LOW);

    done_flag_a: assert property (@(posedge clock) disable iff (rst)
        finish |=> conversion_done_flag && !conversion_busy)
        else $error("done flag not set after conversion");

    single_code_a: assert property (@(posedge clock) disable iff (rst)
        finish && !st.mux_lock[`ARF_MUX_DIFF_POS] |=> st.result == $past(pos_sample))
        else $error("single ended result wrong");

    unipolar_clamp_a: assert property (@(posedge clock) disable iff (rst)
        finish && st.mux_lock[`ARF_MUX_DIFF_POS] && !st.bip_lock && neg_sample > pos_sample
        |=> st.result == `ARF_CODE_ZERO)
        else $error("unipolar result not clamped to zero");

    diff_gain_a: assert property (@(posedge clock) disable iff (rst)
        finish && st.mux_lock[`ARF_MUX_DIFF_POS] && !st.bip_lock
        && pos_sample >= neg_sample && (pos_sample - neg_sample) < 10'h033
        |=> st.result == $past(uni_expect[9:0]))
        else $error("differential gain wrong");

    bipolar_lock_a: assert property (@(posedge clock) disable iff (rst)
        st.fsm == ARF_IDLE && converter_enable && conversion_start
        |=> conversion_busy && st.bip_lock == $past(bipolar_select))
        else $error("bipolar mode not captured at start");

    bipolar_sign_a: assert property (@(posedge clock) disable iff (rst)
        finish && st.mux_lock[`ARF_MUX_DIFF_POS] && st.bip_lock && neg_sample > pos_sample
        |=> result_sign_bit && st.result >= `ARF_BIP_MIN)
        else $error("bipolar negative result lacks sign");

    sign_place_a: assert property (@(posedge clock) disable iff (rst)
        !$past(left_adjust_select) |-> result_high_byte[1] == result_sign_bit)
        else $error("sign bit not in high register");

    left_adjust_a: assert property (@(posedge clock) disable iff (rst)
        left_adjust_select ##1 1'b1 |-> result_low_byte[5:0] == `ARF_PAD_LOW
        && result_high_byte == st.result[9:2])
        else $error("left adjust not applied");

    right_split_a: assert property (@(posedge clock) disable iff (rst)
        !left_adjust_select |=> result_high_byte == {`ARF_PAD_HIGH, st.result[9:8]}
        && result_low_byte == st.result[7:0])
        else $error("right adjust split wrong");

    refout_hiz_a: assert property (@(posedge clock) disable iff (rst)
        !reference_output_enable || !converter_enable |=> !reference_output_drive)
        else $error("reference pin driven while disabled");

    refout_level_a: assert property (@(posedge clock) disable iff (rst)
        converter_enable && reference_output_enable && reference_select == `ARF_REFS_2V56
        |=> reference_output_drive && reference_output_level_high)
        else $error("reference output level wrong");

    ref_select_a: assert property (@(posedge clock) disable iff (rst)
        st.fsm == ARF_IDLE && reference_select == `ARF_REFS_1V1 && !external_reference_enable
        |=> reference_source == ARF_REF_INT_1V1)
        else $error("internal 1.1V reference not selected");

endmodule : arf_result_refout

// *** tb/arf_far_pins.sv ***
// Purpose: model of the analog input pins facing the result formatter
// Assumes: the core samples for lag cycles once busy rises
// Notes:   outside the sample pulse the levels show their inverse, never a held value
`timescale 1ns/1ps
module arf_far_pins
    import arf_pkg::*;
(
    input  wire logic       clock,         // 100 MHz clock
    input  wire logic       busy,          // conversion in progress
    input  wire logic [4:0] lag,           // cycles from busy to sample pulse
    input  wire logic [9:0] lvl_pos,       // positive pin level code
    input  wire logic [9:0] lvl_neg,       // negative pin level code
    output logic            sample_valid,  // sampling finished, pulse
    output logic      [9:0] pos_sample,    // positive sample code
    output logic      [9:0] neg_sample     // negative sample code
);
    logic [5:0] cnt;

    // count busy cycles; sample pulse lands at least one cycle after start
    always_ff @(posedge clock) begin
        if (!busy) cnt <= 6'h00;
        else       cnt <= cnt + 6'h01;
    end

    // samples are only trustworthy inside the pulse, so garble them elsewhere
    assign sample_valid = busy && (cnt == {1'b0, lag});
    assign pos_sample   = sample_valid ? lvl_pos : ~lvl_pos;
    assign neg_sample   = sample_valid ? lvl_neg : ~lvl_neg;
endmodule : arf_far_pins

// *** tb/tb_top.sv ***
// Purpose: self-checking bench of result formatting and reference output control
// Assumes: inputs driven 1 ns after the rising edge
// Notes:   pull-up and pin driver of the reference pin are assumed off by software
`timescale 1ns/1ps
`include "arf_cfg.svh"
module tb_top
    import arf_pkg::*;
;
    logic clock, rst, converter_enable, conversion_start, sample_valid;
    logic [9:0] pos_sample, neg_sample, lvl_pos, lvl_neg;
    logic [4:0] input_channel_select, lag;
    logic bipolar_select, left_adjust_select, external_reference_enable;
    logic reference_output_enable, flag_clear, conversion_busy, conversion_done_flag;
    logic [1:0] reference_select;
    logic [7:0] result_low_byte, result_high_byte;
    logic result_sign_bit, reference_output_drive, reference_output_level_high;
    logic temp_setup_error;
    arf_ref_t reference_source;
    int bad_count, n_checks;

    arf_result_refout u_dut (.clock(clock), .rst(rst), .converter_enable(converter_enable),
        .conversion_start(conversion_start), .sample_valid(sample_valid),
        .pos_sample(pos_sample), .neg_sample(neg_sample),
        .input_channel_select(input_channel_select), .bipolar_select(bipolar_select),
        .left_adjust_select(left_adjust_select), .reference_select(reference_select),
        .external_reference_enable(external_reference_enable),
        .reference_output_enable(reference_output_enable), .flag_clear(flag_clear),
        .conversion_busy(conversion_busy), .conversion_done_flag(conversion_done_flag),
        .result_low_byte(result_low_byte), .result_high_byte(result_high_byte),
        .result_sign_bit(result_sign_bit), .reference_source(reference_source),
        .reference_output_drive(reference_output_drive),
        .reference_output_level_high(reference_output_level_high),
        .temp_setup_error(temp_setup_error));

    arf_far_pins u_pins (.clock(clock), .busy(conversion_busy), .lag(lag),
        .lvl_pos(lvl_pos), .lvl_neg(lvl_neg), .sample_valid(sample_valid),
        .pos_sample(pos_sample), .neg_sample(neg_sample));

    // free running clock, 10 ns period
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic step();
        @(posedge clock);
        #1;
    endtask : step

    task automatic conclude();
        if (bad_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude

    // expected code worked out from the transfer formulas
    function automatic logic [9:0] exp_code(input logic [4:0] ch, input logic bip,
                                            input logic [9:0] p, input logic [9:0] n);
        int d, g;
        if (!ch[4]) return p;
        g = ch[0] ? 20 : 8;
        d = (int'(p) - int'(n)) * g;
        if (!bip) return (d < 0) ? 10'h000 : ((d > 1023) ? 10'h3FF : 10'(d));
        d = d >>> 1;
        if (d > 511) d = 511;
        if (d < -512) d = -512;
        return 10'(d);
    endfunction : exp_code

    // one conversion, right adjusted, then the flag is cleared
    task automatic conv(input logic [4:0] ch, input logic bip, input logic [9:0] p,
                        input logic [9:0] n, input logic [4:0] lg);
        logic [9:0] r;
        r = exp_code(ch, bip, p, n);
        input_channel_select = ch;
        bipolar_select = bip;
        lvl_pos = p;
        lvl_neg = n;
        lag = lg;
        conversion_start = 1'b1;
        step();
        conversion_start = 1'b0;
        for (int i = 0; i < 40 && conversion_done_flag !== 1'b1; i++) step();
        check("done flag", conversion_done_flag, 1'b1);
        check("busy", conversion_busy, 1'b0);
        check("high byte", result_high_byte, {6'h00, r[9:8]});
        check("low byte", result_low_byte, r[7:0]);
        check("sign bit", result_sign_bit, r[9]);
        flag_clear = 1'b1;
        step();
        flag_clear = 1'b0;
        check("flag cleared", conversion_done_flag, 1'b0);
    endtask : conv

    // table of single, unipolar and bipolar cases, boundaries included
    task automatic test_codes();
        logic [4:0] ch [12] = '{5'h00, 5'h00, 5'h10, 5'h11, 5'h10, 5'h11,
                                5'h10, 5'h11, 5'h11, 5'h10, 5'h10, 5'h11};
        logic       bp [12] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 0, 0};
        logic [9:0] ps [12] = '{10'h3FF, 10'h000, 10'h014, 10'h014, 10'h005, 10'h064,
                                10'h000, 10'h000, 10'h064, 10'h00A, 10'h000, 10'h00A};
        logic [9:0] ng [12] = '{10'h000, 10'h000, 10'h00A, 10'h00A, 10'h009, 10'h000,
                                10'h00A, 10'h3FF, 10'h000, 10'h000, 10'h00A, 10'h000};
        for (int i = 0; i < 12; i++) conv(ch[i], bp[i], ps[i], ng[i], (i % 2) ? 5'h06 : 5'h01);
        check("code 8x", exp_code(5'h10, 0, 10'h014, 10'h00A), 10'h050);
        check("clamp zero", exp_code(5'h10, 0, 10'h005, 10'h009), 10'h000);
        check("bipolar min", exp_code(5'h11, 1, 10'h000, 10'h3FF), 10'h200);
    endtask : test_codes

    // adjust toggles re-present the last bipolar result next cycle
    task automatic test_adjust();
        conv(5'h10, 1'b1, 10'h000, 10'h00A, 5'h02);
        left_adjust_select = 1'b1;
        step();
        check("left high", result_high_byte, 8'hF6);
        check("left low", result_low_byte, 8'h00);
        left_adjust_select = 1'b0;
        step();
        check("right low", result_low_byte, 8'hD8);
    endtask : test_adjust

    // start refused while off; switching off mid conversion aborts it
    task automatic test_abort();
        converter_enable = 1'b0;
        conversion_start = 1'b1;
        step();
        conversion_start = 1'b0;
        step();
        check("busy while off", conversion_busy, 1'b0);
        converter_enable = 1'b1;
        lag = 5'h14;
        conversion_start = 1'b1;
        step();
        conversion_start = 1'b0;
        step();
        check("busy", conversion_busy, 1'b1);
        converter_enable = 1'b0;
        step();
        check("aborted", conversion_busy, 1'b0);
        check("no flag", conversion_done_flag, 1'b0);
        converter_enable = 1'b1;
        step();
    endtask : test_abort

    // walk enable, output enable and select; then external enable and temperature
    task automatic test_ref();
        logic [1:0] s;
        for (int k = 0; k < 16; k++) begin
            s = k[1:0];
            converter_enable = k[3];
            reference_output_enable = k[2];
            reference_select = s;
            step();
            check("ref drive", reference_output_drive, k[3] & k[2] & s[0]);
            if (k[3] & k[2] & s[0]) begin
                check("ref level", reference_output_level_high, s[1]);
            end
            check("ref source", reference_source, s[0] ? {1'b1, s[1]} : 2'h0);
        end
        external_reference_enable = 1'b1;
        reference_select = 2'h0;
        step();
        check("ext source", reference_source, 2'h1);
        external_reference_enable = 1'b0;
        reference_output_enable = 1'b0;
        converter_enable = 1'b1;
        input_channel_select = 5'h0B;
        // temperature set up with each of the four selects; only the 1.1V one gives no error
        for (int k = 0; k < 4; k++) begin
            reference_select = k[1:0];
            step();
            check("temp error", temp_setup_error, k != 1);
        end
        // software keeps the temperature channel on the internal 1.1V reference
        reference_select = `ARF_REFS_1V1;
        step();
        check("temp ok", temp_setup_error, 1'b0);
        conv(5'h0B, 1'b0, 10'h144, 10'h000, 5'h03);
    endtask : test_ref

    // reference pin pull-up and driver assumed off by software
    initial begin
        {rst, converter_enable, conversion_start, bipolar_select, left_adjust_select} = 5'h10;
        {external_reference_enable, reference_output_enable, flag_clear} = 3'h0;
        reference_select = 2'h0;
        input_channel_select = 5'h00;
        lvl_pos = 10'h000;
        lvl_neg = 10'h000;
        lag = 5'h01;
        bad_count = 0;
        n_checks = 0;
        repeat (3) step();
        rst = 1'b0;
        step();
        check("reset bytes", {result_high_byte, result_low_byte}, 16'h0000);
        check("reset flag", conversion_done_flag, 1'b0);
        check("reset source", reference_source, 2'h0);
        check("reset drive", reference_output_drive, 1'b0);
        converter_enable = 1'b1;
        step();
        test_codes();
        test_adjust();
        test_abort();
        test_ref();
        conclude();
    end

    // watchdog well beyond the 124 cycles the tests need
    initial begin
        #200000;
        bad_count++;
        conclude();
    end
endmodule : tb_top
